// *** msbu_branch_unit.sv ***
// Microsequencer slice: flag tests, address register, immediate and computed branches.
//
// Overview of operation
// - Test op computes ALU on branch_reg or memory word and pad; zero set when result is FFh.
// - Logic and pass-through ALU functions leave the carry flag alone.
// - Add or increment with carry out sets the carry flag.
// - Subtract or decrement producing a borrow clears the carry flag.
// - Test op writes neither branch_reg nor the scratch pad, only flags.
// - scratch_sel picks one of sixteen scratch pad words.
// - Address increment adds one to the memory address register.
// - Offset load writes an 8-bit immediate into address bits 7 to 0.
// - Page load writes two bits into address bits 9 and 8.
// - Immediate branch takes page from bits 12:11, offset from bits 8:0.
// - Unconditional immediate branch loads the program counter with the target.
// - Conditional immediate branch jumps on carry, zero or bits 0,1,4,7; else advances.
// - Memory-sourced computed branch offset is ALU of memory word and pad word.
// - Computed branch page comes from the 2-bit cstore_page_sel field.
// - Computed branches change no data, pad, branch_reg or flag.
// - Conditional computed branch jumps only when set; otherwise counter plus one.
// - Computed branch conditions: carry, zero, branch_reg bits 0, 1, 4, 7.
// - Register-sourced computed branch uses ALU of branch_reg and pad word.
// - Compare sets zero on equality and carry when B is below the pad word.
`timescale 1ns/1ps

module msbu_branch_unit (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst,
    // APB register port.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Control store.
    output logic [msbu_pkg::MSBU_PC_W-1:0] cstore_addr,
    input wire logic [msbu_pkg::MSBU_IW-1:0] cstore_data,
    // Data memory read port.
    output logic [msbu_pkg::MSBU_MAR_W-1:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    // Status.
    output logic running
);
    import msbu_pkg::*;

    msbu_state_t st;
    msbu_state_t next_st;

    logic [3:0] op;
    logic [2:0] cond;
    logic [3:0] func;
    logic [3:0] scratch_sel;
    logic [1:0] cstore_page_sel;
    logic memory_source;
    logic [7:0] a_op;
    logic [7:0] b_op;
    logic [8:0] res9;
    logic arith;
    logic carry_new;
    logic cond_true;
    logic exec;
    logic [MSBU_PC_W-1:0] seq_pc;
    logic [MSBU_PC_W-1:0] imm_target;
    logic [MSBU_PC_W-1:0] comp_target;
    logic setup;
    logic access;
    logic in_pad;
    logic [3:0] pad_idx;
    logic [31:0] rd_val;
    logic rd_err;

    always_comb begin
        op = cstore_data[MSBU_OP_LSB +: 4];
        cond = cstore_data[MSBU_COND_LSB +: 3];
        func = cstore_data[MSBU_FUNC_LSB +: 4];
        scratch_sel = cstore_data[MSBU_SEL_LSB +: 4];
        cstore_page_sel = cstore_data[MSBU_PAGE_LSB +: 2];
        memory_source = cstore_data[MSBU_SRC_BIT];
        a_op = st.pad[scratch_sel];
        b_op = memory_source ? mem_rdata : st.breg;
        arith = 1'b0;
        carry_new = st.carry;
        case (func)
            MSBU_F_ADD: begin
                res9 = {1'b0, b_op} + {1'b0, a_op};
                arith = 1'b1;
                carry_new = res9[8];
            end
            MSBU_F_INC: begin
                res9 = {1'b0, b_op} + 9'h001;
                arith = 1'b1;
                carry_new = res9[8];
            end
            MSBU_F_SUB: begin
                res9 = {1'b0, b_op} - {1'b0, a_op};
                arith = 1'b1;
                carry_new = ~res9[8];
            end
            MSBU_F_DEC: begin
                res9 = {1'b0, b_op} - 9'h001;
                arith = 1'b1;
                carry_new = ~res9[8];
            end
            MSBU_F_AND: res9 = {1'b0, a_op & b_op};
            MSBU_F_OR: res9 = {1'b0, a_op | b_op};
            MSBU_F_XOR: res9 = {1'b0, a_op ^ b_op};
            MSBU_F_ORNOT: res9 = {1'b0, a_op | ~b_op};
            MSBU_F_PASS_A: res9 = {1'b0, a_op};
            MSBU_F_PASS_B: res9 = {1'b0, b_op};
            default: res9 = {1'b0, b_op};
        endcase
        case (cond)
            MSBU_C_ALWAYS: cond_true = 1'b1;
            MSBU_C_CARRY: cond_true = st.carry;
            MSBU_C_ZERO: cond_true = st.zero;
            MSBU_C_B0: cond_true = st.breg[0];
            MSBU_C_B1: cond_true = st.breg[1];
            MSBU_C_B4: cond_true = st.breg[4];
            MSBU_C_B7: cond_true = st.breg[7];
            default: cond_true = 1'b0;
        endcase
        seq_pc = st.pc + 11'h001;
        imm_target = {cstore_data[MSBU_PAGE_LSB +: 2], cstore_data[MSBU_OFS_LSB +: 9]};
        comp_target = {cstore_page_sel, 1'b0, res9[7:0]};
    end

    // APB decode and read data; the read value is captured in the setup cycle.
    always_comb begin
        setup = psel & ~penable;
        access = psel & penable;
        in_pad = (paddr[11:6] == MSBU_A_PAD_HI) && (paddr[1:0] == 2'b00);
        pad_idx = paddr[5:2];
        rd_err = 1'b0;
        rd_val = 32'h0000_0000;
        if (in_pad) begin
            rd_val[7:0] = st.pad[pad_idx];
        end else begin
            case (paddr)
                MSBU_A_CTRL: begin
                    rd_val[MSBU_CTRL_RUN] = (st.mode == MSBU_RUN);
                    rd_val[MSBU_CTRL_STEP] = (st.mode == MSBU_STEP);
                end
                MSBU_A_STATUS: begin
                    rd_val[0] = st.zero;
                    rd_val[1] = st.carry;
                    rd_val[MSBU_STAT_PC_LSB +: MSBU_PC_W] = st.pc;
                end
                MSBU_A_MAR: rd_val[MSBU_MAR_W-1:0] = st.mar;
                MSBU_A_BRANCH: rd_val[7:0] = st.breg;
                MSBU_A_PC: rd_val[MSBU_PC_W-1:0] = st.pc;
                default: rd_err = 1'b1;
            endcase
        end
    end

    always_comb begin
        next_st = st;
        exec = (st.mode == MSBU_RUN) || (st.mode == MSBU_STEP);
        if (exec) begin
            next_st.pc = seq_pc;
            if (st.mode == MSBU_STEP) begin
                next_st.mode = MSBU_HALT;
            end
            case (op)
                MSBU_OP_NO_DEST: begin
                    // Only flags change here; branch_reg and pad stay.
                    next_st.zero = (res9[7:0] == MSBU_ALL_ONES);
                    if (arith) begin
                        next_st.carry = carry_new;
                    end
                end
                MSBU_OP_ADDR_INC: begin
                    next_st.mar = st.mar + 10'h001;
                end
                MSBU_OP_ADDR_OFS: begin
                    next_st.mar[7:0] = cstore_data[MSBU_IMM_LSB +: 8];
                end
                MSBU_OP_ADDR_PAGE: begin
                    next_st.mar[9:8] = cstore_data[MSBU_IMM_LSB +: 2];
                end
                MSBU_OP_IMM_BR: begin
                    if (cond_true) begin
                        next_st.pc = imm_target;
                    end
                end
                MSBU_OP_COMP_BR: begin
                    // No data, pad, branch_reg or flag is written on this path.
                    if (cond_true) begin
                        next_st.pc = comp_target;
                    end
                end
                MSBU_OP_COMPARE: begin
                    next_st.zero = (b_op == a_op);
                    next_st.carry = (b_op < a_op);
                end
                default: begin
                end
            endcase
        end
        if (setup) begin
            next_st.prdata = rd_err ? 32'h0000_0000 : rd_val;
            next_st.pslverr = rd_err;
        end
        // Software writes take precedence over execution in the same cycle.
        if (access && pwrite && !st.pslverr) begin
            if (in_pad) begin
                next_st.pad[pad_idx] = pwdata[7:0];
            end else begin
                case (paddr)
                    MSBU_A_CTRL: begin
                        if (pwdata[MSBU_CTRL_RUN]) begin
                            next_st.mode = MSBU_RUN;
                        end else if (pwdata[MSBU_CTRL_STEP]) begin
                            next_st.mode = MSBU_STEP;
                        end else begin
                            next_st.mode = MSBU_HALT;
                        end
                    end
                    MSBU_A_STATUS: begin
                        next_st.zero = pwdata[0];
                        next_st.carry = pwdata[1];
                    end
                    MSBU_A_MAR: next_st.mar = pwdata[MSBU_MAR_W-1:0];
                    MSBU_A_BRANCH: next_st.breg = pwdata[7:0];
                    MSBU_A_PC: next_st.pc = pwdata[MSBU_PC_W-1:0];
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st.mode <= MSBU_HALT;
            st.pc <= MSBU_PC_RST;
            st.mar <= MSBU_MAR_RST;
            st.breg <= MSBU_BYTE_RST;
            st.carry <= 1'b0;
            st.zero <= 1'b0;
            st.pad <= '0;
            st.prdata <= 32'h0000_0000;
            st.pslverr <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.prdata;
    assign pslverr = st.pslverr & psel & penable;
    assign pready = psel & penable;
    assign cstore_addr = st.pc;
    assign mem_addr = st.mar;
    assign running = (st.mode != MSBU_HALT);

endmodule // msbu_branch_unit

// *** msbu_pkg.sv ***
// Constants, encodings and state types shared by the microsequencer branch unit.
package msbu_pkg;

    // Microinstruction word and field layout.
    localparam int unsigned MSBU_IW = 20;
    localparam int unsigned MSBU_OP_LSB = 16;
    localparam int unsigned MSBU_COND_LSB = 13;
    localparam int unsigned MSBU_PAGE_LSB = 11;
    localparam int unsigned MSBU_SRC_BIT = 8;
    localparam int unsigned MSBU_FUNC_LSB = 4;
    localparam int unsigned MSBU_SEL_LSB = 0;
    localparam int unsigned MSBU_OFS_LSB = 0;
    localparam int unsigned MSBU_IMM_LSB = 0;

    // Widths of the sequencer state.
    localparam int unsigned MSBU_PC_W = 11;
    localparam int unsigned MSBU_MAR_W = 10;
    localparam int unsigned MSBU_PADS = 16;

    // Operation codes.
    localparam logic [3:0] MSBU_OP_NOP = 4'h0;
    localparam logic [3:0] MSBU_OP_NO_DEST = 4'h1;
    localparam logic [3:0] MSBU_OP_ADDR_INC = 4'h2;
    localparam logic [3:0] MSBU_OP_ADDR_OFS = 4'h3;
    localparam logic [3:0] MSBU_OP_ADDR_PAGE = 4'h4;
    localparam logic [3:0] MSBU_OP_IMM_BR = 4'h5;
    localparam logic [3:0] MSBU_OP_COMP_BR = 4'h6;
    localparam logic [3:0] MSBU_OP_COMPARE = 4'h7;

    // Branch conditions.
    localparam logic [2:0] MSBU_C_ALWAYS = 3'h0;
    localparam logic [2:0] MSBU_C_CARRY = 3'h1;
    localparam logic [2:0] MSBU_C_ZERO = 3'h2;
    localparam logic [2:0] MSBU_C_B0 = 3'h3;
    localparam logic [2:0] MSBU_C_B1 = 3'h4;
    localparam logic [2:0] MSBU_C_B4 = 3'h5;
    localparam logic [2:0] MSBU_C_B7 = 3'h6;

    // ALU functions; A is the scratch pad word, B is the memory word or branch register.
    localparam logic [3:0] MSBU_F_ADD = 4'h0;
    localparam logic [3:0] MSBU_F_SUB = 4'h1;
    localparam logic [3:0] MSBU_F_INC = 4'h2;
    localparam logic [3:0] MSBU_F_DEC = 4'h3;
    localparam logic [3:0] MSBU_F_AND = 4'h4;
    localparam logic [3:0] MSBU_F_OR = 4'h5;
    localparam logic [3:0] MSBU_F_XOR = 4'h6;
    localparam logic [3:0] MSBU_F_ORNOT = 4'h7;
    localparam logic [3:0] MSBU_F_PASS_A = 4'h8;
    localparam logic [3:0] MSBU_F_PASS_B = 4'h9;

    localparam logic [7:0] MSBU_ALL_ONES = 8'hFF;

    // Register byte addresses.
    localparam logic [11:0] MSBU_A_CTRL = 12'h000;
    localparam logic [11:0] MSBU_A_STATUS = 12'h004;
    localparam logic [11:0] MSBU_A_MAR = 12'h008;
    localparam logic [11:0] MSBU_A_BRANCH = 12'h00C;
    localparam logic [11:0] MSBU_A_PC = 12'h010;
    localparam logic [5:0] MSBU_A_PAD_HI = 6'h01;
    localparam int unsigned MSBU_CTRL_RUN = 0;
    localparam int unsigned MSBU_CTRL_STEP = 1;
    localparam int unsigned MSBU_STAT_PC_LSB = 16;

    // Reset values.
    localparam logic [10:0] MSBU_PC_RST = 11'h000;
    localparam logic [9:0] MSBU_MAR_RST = 10'h000;
    localparam logic [7:0] MSBU_BYTE_RST = 8'h00;

    typedef enum logic [1:0] {
        MSBU_HALT = 2'b00,
        MSBU_RUN = 2'b01,
        MSBU_STEP = 2'b11
    } msbu_mode_t;

    typedef struct packed {
        msbu_mode_t mode;
        logic [MSBU_PC_W-1:0] pc;
        logic [MSBU_MAR_W-1:0] mar;
        logic [7:0] breg;
        logic carry;
        logic zero;
        logic [MSBU_PADS-1:0][7:0] pad;
        logic [31:0] prdata;
        logic pslverr;
    } msbu_state_t;

endpackage

// *** msbu_cstore_model.sv ***
// Control store and data memory model facing the branch unit.
`timescale 1ns/1ps

module msbu_cstore_model (
    // Microinstruction fetch.
    input wire logic [msbu_pkg::MSBU_PC_W-1:0] cstore_addr,
    output logic [msbu_pkg::MSBU_IW-1:0] cstore_data,
    // Data memory read.
    input wire logic [msbu_pkg::MSBU_MAR_W-1:0] mem_addr,
    output logic [7:0] mem_rdata
);
    import msbu_pkg::*;
    logic [MSBU_IW-1:0] cs [0:2047];
    logic [7:0] dm [0:1023];

    // Unwritten words are no-ops so a free run never fetches unknowns.
    initial begin
        for (int i = 0; i < 2048; i++) begin
            cs[i] = 20'h00000;
        end
        for (int i = 0; i < 1024; i++) begin
            dm[i] = 8'hA5;
        end
    end

    assign cstore_data = cs[cstore_addr];
    assign mem_rdata = dm[mem_addr];
endmodule // msbu_cstore_model

// *** msbu_branch_unit_sva.sv ***
// Port-level assertions for the microsequencer branch unit.
`timescale 1ns/1ps

module msbu_branch_unit_sva (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst,
    // APB register port.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // Sequencer.
    input wire logic [msbu_pkg::MSBU_PC_W-1:0] cstore_addr,
    input wire logic [msbu_pkg::MSBU_IW-1:0] cstore_data,
    input wire logic [msbu_pkg::MSBU_MAR_W-1:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    input wire logic running
);
    import msbu_pkg::*;
    // An executing edge with no register write overriding its update.
    logic ex;
    logic [3:0] op;
    logic [2:0] cond;
    assign ex = running && !(psel && penable && pwrite);
    assign op = cstore_data[19:16];
    assign cond = cstore_data[15:13];
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    ready_in_access_a: assert property (psel && penable |-> pready)
        else $error("pready low in access cycle");
    mar_increment_a: assert property (ex && op == MSBU_OP_ADDR_INC
        |=> mem_addr == $past(mem_addr) + 10'h001) else $error("address increment wrong");
    mar_offset_load_a: assert property (ex && op == MSBU_OP_ADDR_OFS
        |=> mem_addr == {$past(mem_addr[9:8]), $past(cstore_data[7:0])})
        else $error("offset load wrong");
    mar_page_load_a: assert property (ex && op == MSBU_OP_ADDR_PAGE
        |=> mem_addr == {$past(cstore_data[1:0]), $past(mem_addr[7:0])})
        else $error("page load wrong");
    imm_jump_a: assert property (ex && op == MSBU_OP_IMM_BR && cond == MSBU_C_ALWAYS
        |=> cstore_addr == {$past(cstore_data[12:11]), $past(cstore_data[8:0])})
        else $error("immediate jump target wrong");
    mem_target_a: assert property (ex && op == MSBU_OP_COMP_BR && cond == 3'h0
        && cstore_data[8] && cstore_data[7:4] == MSBU_F_PASS_B
        |=> cstore_addr == {$past(cstore_data[12:11]), 1'b0, $past(mem_rdata)})
        else $error("computed target wrong");
    pc_advance_a: assert property (ex && (op == MSBU_OP_NOP || cond == 3'h7
        && (op == MSBU_OP_IMM_BR || op == MSBU_OP_COMP_BR))
        |=> cstore_addr == $past(cstore_addr) + 11'h001) else $error("pc did not advance");
    mar_kept_a: assert property (ex && (op == MSBU_OP_COMP_BR || op == MSBU_OP_NO_DEST)
        |=> $stable(mem_addr)) else $error("address register disturbed");
    step_once_a: assert property (psel && penable && pwrite && paddr == MSBU_A_CTRL
        && pwdata[1:0] == 2'b10 && !running |=> running ##1 !running)
        else $error("single step not one cycle");
    bad_addr_err_a: assert property (psel && penable && paddr[1:0] != 2'b00 |-> pslverr)
        else $error("misaligned access not refused");

    cover property (ex && op == MSBU_OP_IMM_BR);
    cover property (ex && op == MSBU_OP_COMP_BR);
    cover property (pslverr && pready);
endmodule // msbu_branch_unit_sva

bind msbu_branch_unit msbu_branch_unit_sva u_sva (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .cstore_addr(cstore_addr), .cstore_data(cstore_data),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata), .running(running));

// *** msbu_tb.sv ***
// Self-checking bench for the microsequencer branch unit.
`timescale 1ns/1ps

module testbench;
    import msbu_pkg::*;
    localparam logic [10:0] BASE = 11'h005;
    localparam logic [10:0] NXT = 11'h006;
    logic clock, rst, psel, penable, pwrite, pready, pslverr, running, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [MSBU_PC_W-1:0] cstore_addr;
    logic [MSBU_IW-1:0] cstore_data;
    logic [MSBU_MAR_W-1:0] mem_addr;
    logic [7:0] mem_rdata, br, sum;
    logic [5:0] vec;
    logic [1:0] fl;
    int fail_count = 0;
    int n_tests = 0;
    int cycles = 0;

    msbu_branch_unit u_dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cstore_addr(cstore_addr), .cstore_data(cstore_data),
        .mem_addr(mem_addr), .mem_rdata(mem_rdata), .running(running));
    msbu_cstore_model u_ram (.cstore_addr(cstore_addr), .cstore_data(cstore_data),
        .mem_addr(mem_addr), .mem_rdata(mem_rdata));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            close_out();
        end
    end

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; the request holds until pready is seen at an edge.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        // The slave answers in the first access cycle, with no wait state.
        chk(32'(n), 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
        chk({31'h0, err}, 32'h0);
    endtask

    function automatic logic [19:0] mk(input logic [3:0] op, input logic [2:0] c,
        input logic [1:0] pg, input logic [3:0] fn, input logic [3:0] sel);
        return {op, c, pg, 3'b000, fn, sel};
    endfunction

    // Places one word at BASE and executes it with a single step.
    task automatic step(input logic [19:0] w);
        u_ram.cs[BASE] = w;
        apb(1'b1, MSBU_A_PC, {21'h0, BASE});
        apb(1'b1, MSBU_A_CTRL, 32'h2);
        repeat (3) @(posedge clock);
    endtask

    task automatic run(input logic [19:0] w, input logic [7:0] b, input logic [7:0] p,
        input logic [1:0] f, input logic [10:0] pc, input logic [1:0] ef);
        apb(1'b1, MSBU_A_BRANCH, {24'h0, b});
        apb(1'b1, {MSBU_A_PAD_HI, w[3:0], 2'b00}, {24'h0, p});
        apb(1'b1, MSBU_A_STATUS, {30'h0, f});
        step(w);
        rd_chk(MSBU_A_STATUS, {5'h0, pc, 14'h0, ef});
        rd_chk(MSBU_A_BRANCH, {24'h0, b});
        rd_chk({MSBU_A_PAD_HI, w[3:0], 2'b00}, {24'h0, p});
    endtask

    task automatic mar_op(input logic [19:0] w, input logic [9:0] m0, input logic [9:0] me);
        apb(1'b1, MSBU_A_MAR, {22'h0, m0});
        step(w);
        chk({22'h0, mem_addr}, {22'h0, me});
        rd_chk(MSBU_A_MAR, {22'h0, me});
    endtask

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        for (int a = 0; a < 5; a++) begin
            rd_chk(12'(a * 4), 32'h0);
        end
        apb(1'b0, 12'h0FC, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b0, 12'h006, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        run(mk(MSBU_OP_NO_DEST, 3'h0, 2'h0, MSBU_F_ADD, 4'h0), 8'hF0, 8'h0F, 2'b00, NXT, 2'b01);
        run(mk(MSBU_OP_NO_DEST, 3'h0, 2'h0, MSBU_F_ADD, 4'hF), 8'h80, 8'h80, 2'b01, NXT, 2'b10);
        run(mk(MSBU_OP_NO_DEST, 3'h0, 2'h0, MSBU_F_INC, 4'h7), 8'hFF, 8'h00, 2'b00, NXT, 2'b10);
        run(mk(MSBU_OP_NO_DEST, 3'h0, 2'h0, MSBU_F_SUB, 4'h1), 8'h01, 8'h02, 2'b10, NXT, 2'b01);
        run(mk(MSBU_OP_NO_DEST, 3'h0, 2'h0, MSBU_F_DEC, 4'h2), 8'h00, 8'h00, 2'b10, NXT, 2'b01);
        for (int fn = 4; fn < 10; fn++) begin
            for (int c = 0; c < 2; c++) begin
                run(mk(MSBU_OP_NO_DEST, 3'h0, 2'h0, 4'(fn), 4'h9), 8'hFF, 8'h0F, {c[0], 1'b0}, NXT,
                    {c[0], fn == 5 || fn == 9});
            end
        end
        run(mk(MSBU_OP_COMPARE, 3'h0, 2'h0, 4'h0, 4'h4), 8'h05, 8'h09, 2'b01, NXT, 2'b10);
        run(mk(MSBU_OP_COMPARE, 3'h0, 2'h0, 4'h0, 4'h4), 8'h09, 8'h09, 2'b10, NXT, 2'b01);
        run(mk(MSBU_OP_NOP, 3'h0, 2'h0, 4'h0, 4'h0), 8'h00, 8'h00, 2'b11, NXT, 2'b11);
        // An undefined opcode is a no-op: flags stay although its add would carry.
        run(mk(4'hF, 3'h0, 2'h0, MSBU_F_ADD, 4'h0), 8'hFF, 8'h01, 2'b00, NXT, 2'b00);
        run({MSBU_OP_IMM_BR, MSBU_C_ALWAYS, 2'b11, 2'b00, 9'h1FF}, 8'h00, 8'h00, 2'b00,
            11'h7FF, 2'b00);
        for (int k = 0; k < 2; k++) begin
            for (int c = 1; c < 8; c++) begin
                for (int t = 0; t < 2; t++) begin
                    vec = (t == 1) ? 6'h01 << (c - 1) : ~(6'h01 << (c - 1));
                    fl = {vec[0], vec[1]};
                    br = {vec[5], 2'b00, vec[4], 2'b00, vec[3], vec[2]};
                    sum = br + 8'h21;
                    run(k == 0 ? {MSBU_OP_IMM_BR, c[2:0], 2'b10, 2'b00, 9'h13C}
                        : mk(MSBU_OP_COMP_BR, c[2:0], 2'b01, MSBU_F_ADD, 4'h3), br, 8'h21, fl,
                        (c < 7 && t == 1) ? (k == 0 ? 11'h53C : {3'b010, sum}) : NXT,
                        fl);
                end
            end
        end
        u_ram.dm[10'h2C3] = 8'h5A;
        apb(1'b1, MSBU_A_MAR, 32'h2C3);
        run(mk(MSBU_OP_COMP_BR, MSBU_C_ALWAYS, 2'b11, MSBU_F_PASS_B, 4'h2) | 20'h00100, 8'h00,
            8'h11, 2'b11, 11'h65A, 2'b11);
        run(mk(MSBU_OP_COMP_BR, MSBU_C_ALWAYS, 2'b00, MSBU_F_ADD, 4'h2) | 20'h00100, 8'h00,
            8'h11, 2'b00, 11'h06B, 2'b00);
        run(mk(MSBU_OP_COMP_BR, MSBU_C_ALWAYS, 2'b10, MSBU_F_PASS_A, 4'hE), 8'h33, 8'h7C, 2'b00,
            11'h47C, 2'b00);
        mar_op(mk(MSBU_OP_ADDR_INC, 3'h0, 2'h0, 4'h0, 4'h0), 10'h0FF, 10'h100);
        mar_op(mk(MSBU_OP_ADDR_INC, 3'h0, 2'h0, 4'h0, 4'h0), 10'h3FF, 10'h000);
        mar_op(mk(MSBU_OP_ADDR_OFS, 3'h0, 2'h0, 4'h7, 4'hE), 10'h2C3, 10'h27E);
        mar_op(mk(MSBU_OP_ADDR_PAGE, 3'h0, 2'h0, 4'hF, 4'hD), 10'h27E, 10'h17E);
        // A second reset in mid-run must restore the reset values.
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        rd_chk(MSBU_A_MAR, 32'h0);
        rd_chk(MSBU_A_STATUS, 32'h0);
        rd_chk(12'h078, 32'h0);
        apb(1'b1, MSBU_A_CTRL, 32'h1);
        rd_chk(MSBU_A_CTRL, 32'h1);
        chk({31'h0, running}, 32'h1);
        apb(1'b1, MSBU_A_CTRL, 32'h0);
        @(posedge clock);
        chk({31'h0, running}, 32'h0);
        close_out();
    end
endmodule // testbench
